// >>> rtl/atsc_consts.svh
// Constants of the test slave controller: offsets, fields, codes, resets.
// Assumes inclusion by bare name, also from the testbench, which sits in another folder.
`ifndef ATSC_CONSTS_SVH
`define ATSC_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Window and decode
`define ATSC_OFS_W          12
`define ATSC_OFS_STATE      12'h000
`define ATSC_LOC_LO         2
`define ATSC_LOC_HI         10
`define ATSC_LOC_N          9

// One-hot location bits within the offset
`define ATSC_BIT_COPROC_DATA_IN_DRIVE      10
`define ATSC_BIT_INPUTS     9
`define ATSC_BIT_DIN        8
`define ATSC_BIT_DOUT       7
`define ATSC_BIT_COPROC_DATA_OUT_SAMPLE     6
`define ATSC_BIT_COPROC_INSTR_SAMPLE       5
`define ATSC_BIT_STAT1      4
`define ATSC_BIT_STAT2      3
`define ATSC_BIT_ADDRESS_OUT_SAMPLE       2

////////////////////////////////////////////////////////////////////////////////
// Mode codes written to the state location
`define ATSC_CODE_EXIT      3'h0
`define ATSC_CODE_FUNC      3'h1
`define ATSC_CODE_TAGRAM    3'h2
`define ATSC_CODE_IMMU      3'h3
`define ATSC_CODE_DMMU      3'h4
`define ATSC_CODE_ICACHE    3'h5
`define ATSC_CODE_DCACHE    3'h6
`define ATSC_CODE_TOP       29'h0000000

////////////////////////////////////////////////////////////////////////////////
// Packed input word: bits 25:20 carry no signal
`define ATSC_INP_ZERO_MASK  32'h03F00000

// Status words
`define ATSC_STAT1_W        22
`define ATSC_ST2_IR_LO      25
`define ATSC_ST2_TAP_LO     14
`define ATSC_ST2_MID_LO     18
`define ATSC_ST2_HI_LO      29

// ASB transfer type and reset values
`define ATSC_BTRAN_ADDR     1
`define ATSC_RST_WORD       32'h00000000

`endif

// >>> rtl/atsc_pkg.sv
// Types of the test slave controller.
// Assumes no other package; constants live in the consts header.
package atsc_pkg;

  typedef enum logic [2:0] {
    ATSC_EXIT,
    ATSC_FUNC,
    ATSC_TAGRAM,
    ATSC_IMMU,
    ATSC_DMMU,
    ATSC_ICACHE,
    ATSC_DCACHE
  } atsc_mode_t;

endpackage : atsc_pkg

// >>> rtl/atsc_top.sv
// ASB test slave controller: test mode selection and functional test access.
// Assumes dsel comes from the system decoder and ba is already window-relative
// in its low twelve bits; the core steps on core_step while in functional test.
`include "atsc_consts.svh"

module atsc_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // ASB slave side
  input  wire logic        dsel,
  input  wire logic [31:0] ba,
  input  wire logic [1:0]  btran,
  input  wire logic        bwrite,
  input  wire logic [31:0] bd_in,
  output logic      [31:0] bd_out,
  output logic             bd_oe,
  output logic             bwait,
  output logic             berror,
  output logic             blast,
  // Normal pin side of the core
  input  wire logic [31:0] pin_inputs,
  input  wire logic [31:0] pin_din,
  input  wire logic [31:0] pin_coproc_data_in_drive,
  // Core input side
  output logic      [31:0] core_inputs,
  output logic      [31:0] core_din,
  output logic      [31:0] core_coproc_data_in_drive,
  output logic             core_out_drive_en,
  output logic             core_step,
  output logic             test_functional,
  output logic      [2:0]  test_mode,
  // Core observed outputs
  input  wire logic [31:0] core_dout,
  input  wire logic [31:0] core_coproc_data_out_sample,
  input  wire logic [31:0] core_coproc_instr_sample,
  input  wire logic [21:0] core_status_first_in,
  input  wire logic [2:0]  core_dbg_hi,
  input  wire logic [3:0]  instr_register_bits,
  input  wire logic [6:0]  core_range_scan,
  input  wire logic [3:0]  tap_state_bits,
  input  wire logic [13:0] core_dbg_lo,
  input  wire logic [31:0] address_out_sample
);

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [`ATSC_LOC_N-1:0] loc_decode(input logic [11:0] ofs);
    loc_decode = ofs[`ATSC_LOC_HI:`ATSC_LOC_LO];
  endfunction : loc_decode

  function automatic logic code_valid(input logic [31:0] wd);
    code_valid = (wd[31:3] == `ATSC_CODE_TOP) && (wd[2:0] <= `ATSC_CODE_DCACHE);
  endfunction : code_valid

  function automatic atsc_pkg::atsc_mode_t code_to_mode(input logic [2:0] code);
    atsc_pkg::atsc_mode_t m;
    m = atsc_pkg::ATSC_EXIT;
    case (code)
      `ATSC_CODE_FUNC:   m = atsc_pkg::ATSC_FUNC;
      `ATSC_CODE_TAGRAM: m = atsc_pkg::ATSC_TAGRAM;
      `ATSC_CODE_IMMU:   m = atsc_pkg::ATSC_IMMU;
      `ATSC_CODE_DMMU:   m = atsc_pkg::ATSC_DMMU;
      `ATSC_CODE_ICACHE: m = atsc_pkg::ATSC_ICACHE;
      `ATSC_CODE_DCACHE: m = atsc_pkg::ATSC_DCACHE;
      default:           m = atsc_pkg::ATSC_EXIT;
    endcase
    code_to_mode = m;
  endfunction : code_to_mode

  //////////////////////////////////////////////////////////////////////////////
  // State

  atsc_pkg::atsc_mode_t mode_ff;
  atsc_pkg::atsc_mode_t nxt_mode;

  logic                  dph_ff;
  logic                  dph_wr_ff;
  logic [`ATSC_OFS_W-1:0] dph_ofs_ff;
  logic                  dph_err_ff;
  logic [31:0]           rdata_ff;
  logic [31:0]           nxt_rdata;
  logic [31:0]           coproc_data_in_drive_ff;
  logic [31:0]           inputs_ff;
  logic [31:0]           din_ff;
  logic                  pend_ff;
  logic                  nxt_pend;
  logic                  step_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Address phase

  // Only the low twelve bits matter; the decoder has already matched the base
  wire logic [`ATSC_OFS_W-1:0] ap_ofs   = ba[`ATSC_OFS_W-1:0];
  wire logic                   ap_take  = dsel && btran[`ATSC_BTRAN_ADDR];
  wire logic                   ap_unal  = (ba[1:0] != 2'h0);
  wire logic                   is_func  = (mode_ff == atsc_pkg::ATSC_FUNC);
  wire logic [`ATSC_LOC_N-1:0] ap_loc   = loc_decode(ap_ofs);

  //////////////////////////////////////////////////////////////////////////////
  // Observed word assembly

  // Upper ten bits carry no signal
  wire logic [31:0] stat1_word = {{(32-`ATSC_STAT1_W){1'b0}},
                                  core_status_first_in};
  wire logic [31:0] stat2_word = {core_dbg_hi, instr_register_bits,
                                  core_range_scan, tap_state_bits,
                                  core_dbg_lo};

  // Read sources in location-bit order 2..7; nothing else is reachable
  wire logic [31:0] rd_src [0:5];
  assign rd_src[0] = address_out_sample;
  assign rd_src[1] = stat2_word;
  assign rd_src[2] = stat1_word;
  assign rd_src[3] = core_coproc_instr_sample;
  assign rd_src[4] = core_coproc_data_out_sample;
  assign rd_src[5] = core_dout;

  // AND-OR select; several bits set merges their words, as the tester asked
  wire logic [31:0] rd_term [0:5];
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_rd
      assign rd_term[gi] = rd_src[gi] & {32{ap_loc[gi]}};
    end
  endgenerate

  wire logic [31:0] rd_func = rd_term[0] | rd_term[1] | rd_term[2] |
                              rd_term[3] | rd_term[4] | rd_term[5];

  // Other test modes are outside this block and read as zero
  always_comb begin
    nxt_rdata = `ATSC_RST_WORD;
    if (ap_take && !bwrite && !ap_unal && is_func) begin
      nxt_rdata = rd_func;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data phase write decode

  wire logic [`ATSC_LOC_N-1:0] dp_loc   = loc_decode(dph_ofs_ff);
  wire logic dp_wr_ok    = dph_ff && dph_wr_ff && !dph_err_ff;
  wire logic dp_state_wr = dp_wr_ok && (dph_ofs_ff == `ATSC_OFS_STATE);
  wire logic dp_func_wr  = dp_wr_ok && is_func;
  wire logic wr_coproc_data_in_drive    = dp_func_wr && dp_loc[`ATSC_BIT_COPROC_DATA_IN_DRIVE-`ATSC_LOC_LO];
  wire logic wr_inputs   = dp_func_wr && dp_loc[`ATSC_BIT_INPUTS-`ATSC_LOC_LO];
  wire logic wr_din      = dp_func_wr && dp_loc[`ATSC_BIT_DIN-`ATSC_LOC_LO];
  wire logic wr_any_in   = wr_coproc_data_in_drive || wr_inputs || wr_din;

  // Unknown codes are ignored so a stray write cannot land in an odd mode
  always_comb begin
    nxt_mode = mode_ff;
    if (dp_state_wr && code_valid(bd_in)) begin
      nxt_mode = code_to_mode(bd_in[2:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Core stepping: one step when a write sequence ends

  wire logic seq_end = pend_ff && !wr_any_in && is_func;

  always_comb begin
    nxt_pend = pend_ff;
    if (!is_func) begin
      nxt_pend = 1'b0;
    end else if (wr_any_in) begin
      nxt_pend = 1'b1;
    end else if (seq_end) begin
      nxt_pend = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_ff <= atsc_pkg::ATSC_EXIT;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dph_ff     <= 1'b0;
      dph_wr_ff  <= 1'b0;
      dph_ofs_ff <= `ATSC_OFS_STATE;
      dph_err_ff <= 1'b0;
      rdata_ff   <= `ATSC_RST_WORD;
    end else begin
      dph_ff     <= ap_take;
      dph_wr_ff  <= ap_take && bwrite;
      dph_ofs_ff <= ap_ofs;
      dph_err_ff <= ap_take && ap_unal;
      rdata_ff   <= nxt_rdata;
    end
  end

  // Driven words survive a step so the core sees stable inputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      coproc_data_in_drive_ff  <= `ATSC_RST_WORD;
      inputs_ff <= `ATSC_RST_WORD;
      din_ff    <= `ATSC_RST_WORD;
    end else begin
      if (wr_coproc_data_in_drive) begin
        coproc_data_in_drive_ff <= bd_in;
      end
      if (wr_inputs) begin
        inputs_ff <= bd_in & ~`ATSC_INP_ZERO_MASK;
      end
      if (wr_din) begin
        din_ff <= bd_in;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_ff <= 1'b0;
      step_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      step_ff <= seq_end;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero-wait slave; last is never asserted by this slave
  assign bwait  = 1'b0;
  assign blast  = 1'b0;
  assign berror = dph_ff && dph_err_ff;
  assign bd_out = rdata_ff;
  assign bd_oe  = dph_ff && !dph_wr_ff && !dph_err_ff;

  // Outside functional test the core runs free from its own pins
  assign core_inputs       = is_func ? inputs_ff : pin_inputs;
  assign core_din          = is_func ? din_ff    : pin_din;
  assign core_coproc_data_in_drive        = is_func ? coproc_data_in_drive_ff  : pin_coproc_data_in_drive;
  assign core_out_drive_en = !is_func;
  assign core_step         = is_func ? step_ff : 1'b1;
  assign test_functional   = is_func;
  assign test_mode         = mode_ff;

endmodule : atsc_top

// >>> tb/atsc_chk.sv
// Port checker of the test slave controller.
// Assumes binding to atsc_top; sees only its ports, one clock domain.
module atsc_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // Bus side
  input wire logic        dsel,
  input wire logic [31:0] ba,
  input wire logic [1:0]  btran,
  input wire logic        bwrite,
  input wire logic [31:0] bd_in,
  input wire logic [31:0] bd_out,
  input wire logic        bd_oe,
  input wire logic        bwait,
  input wire logic        berror,
  input wire logic        blast,
  // Core side
  input wire logic [31:0] pin_inputs,
  input wire logic [31:0] core_inputs,
  input wire logic        core_out_drive_en,
  input wire logic        core_step,
  input wire logic        test_functional,
  input wire logic [2:0]  test_mode,
  input wire logic [31:0] core_dout
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire rd  = dsel && btran[1] && !bwrite && ba[1:0] == 2'h0;
  wire wst = dsel && btran[1] && bwrite && ba[11:0] == 12'h000;
  a_no_wait: assert property (!bwait && !blast)
    else $error("wait or last raised");
  a_read_answer: assert property (rd |=> bd_oe && !berror)
    else $error("read not answered next cycle");
  a_bad_align: assert property (dsel && btran[1] && ba[1:0] != 2'h0 |=> berror)
    else $error("misaligned access without error");
  a_mode_set: assert property (wst ##1 bd_in == 32'h00000001 |=> test_mode == 3'h1)
    else $error("mode not set by state write");
  a_mode_keep: assert property (wst ##1 bd_in == 32'h00000007 |=> $stable(test_mode))
    else $error("unknown code changed mode");
  a_func_level: assert property (test_functional == (test_mode == 3'h1))
    else $error("functional flag disagrees with mode");
  a_func_isolate: assert property (test_functional |-> !core_out_drive_en)
    else $error("drivers on in functional test");
  a_pins_back: assert property (!test_functional |->
    core_inputs == pin_inputs && core_out_drive_en && core_step)
    else $error("core not on its pins outside test");
  a_step_pulse: assert property (test_functional && core_step |=> !core_step)
    else $error("core step longer than one cycle");
  a_dout_read: assert property (rd && test_functional && ba[11:0] == 12'h080
    |=> bd_out == $past(core_dout))
    else $error("data out read wrong");
  a_stat1_zero: assert property (rd && test_functional && ba[11:0] == 12'h010
    |=> bd_out[31:22] == 10'h000)
    else $error("status one upper bits not zero");
endmodule : atsc_chk

bind atsc_top atsc_chk u_chk (.sys_clk, .srst, .dsel, .ba, .btran, .bwrite, .bd_in, .bd_out,
  .bd_oe, .bwait, .berror, .blast, .pin_inputs, .core_inputs, .core_out_drive_en,
  .core_step, .test_functional, .test_mode, .core_dout);

// >>> tb/atsc_master.sv
// Bus master model: one transfer at a time, then a turnaround cycle.
// Assumes zero wait states; released lines other than btran show the inverse of their last value.
module atsc_master (
  // Clock
  input  wire logic        sys_clk,
  // Answer
  input  wire logic [31:0] bd_out,
  input  wire logic        berror,
  // Request
  output logic             dsel,
  output logic      [31:0] ba,
  output logic      [1:0]  btran,
  output logic             bwrite,
  output logic      [31:0] bd_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    dsel = 1'b0;
    ba = 32'h00000000;
    btran = 2'h0;
    bwrite = 1'b0;
    bd_in = 32'h00000000;
  end
  // Base is zero, so offsets go out as given
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge sys_clk);
    #1;
    dsel = 1'b1;
    ba = a;
    btran = 2'h2;
    bwrite = wr;
    @(posedge sys_clk);
    #1;
    dsel = 1'b0;
    btran = 2'h0;
    ba = ~a;
    bwrite = ~wr;
    bd_in = wr ? d : ~bd_in;
    // Answer stands through the data phase; taken here, clear of either edge
    rd = bd_out;
    er = berror;
    @(posedge sys_clk);
    #1;
    bd_in = ~bd_in;
  endtask : xfer
endmodule : atsc_master

// >>> tb/test_asb_test_slave_controller.sv
// Testbench of the test slave controller: modes, locations, isolation, stepping.
// Assumes the master model and bound checker; core outputs are random values.
`include "atsc_consts.svh"
module test_asb_test_slave_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, srst = 1'b1, dsel, bwrite, bd_oe, bwait, berror, blast, err;
  logic core_out_drive_en, core_step, test_functional;
  logic [1:0] btran;
  logic [2:0] test_mode, core_dbg_hi = 3'h0;
  logic [3:0] instr_register_bits = 4'h0, tap_state_bits = 4'h0;
  logic [6:0] core_range_scan = 7'h00;
  logic [13:0] core_dbg_lo = 14'h0000;
  logic [21:0] core_status_first_in = 22'h000000;
  logic [31:0] ba, bd_in, bd_out, core_inputs, core_din, core_coproc_data_in_drive, rdat, d, got;
  logic [31:0] pin_inputs = 32'h0, pin_din = 32'h0, pin_coproc_data_in_drive = 32'h0, core_dout = 32'h0;
  logic [31:0] core_coproc_data_out_sample = 32'h0, core_coproc_instr_sample = 32'h0, address_out_sample = 32'h0;
  integer seed = 32'h63C29FF1, errors = 0, cmp_count = 0, n;
  atsc_top uut (.sys_clk, .srst, .dsel, .ba, .btran, .bwrite, .bd_in, .bd_out, .bd_oe,
    .bwait, .berror, .blast, .pin_inputs, .pin_din, .pin_coproc_data_in_drive, .core_inputs, .core_din,
    .core_coproc_data_in_drive, .core_out_drive_en, .core_step, .test_functional, .test_mode, .core_dout,
    .core_coproc_data_out_sample, .core_coproc_instr_sample, .core_status_first_in, .core_dbg_hi, .instr_register_bits,
    .core_range_scan, .tap_state_bits, .core_dbg_lo, .address_out_sample);
  atsc_master m (.sys_clk, .bd_out, .berror, .dsel, .ba, .btran, .bwrite, .bd_in);
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_rd(input int b);
    case (b)
      7: return core_dout;
      6: return core_coproc_data_out_sample;
      5: return core_coproc_instr_sample;
      4: return {10'h000, core_status_first_in};
      3: return {core_dbg_hi, instr_register_bits, core_range_scan, tap_state_bits, core_dbg_lo};
      2: return address_out_sample;
      default: return 32'h00000000;
    endcase
  endfunction : exp_rd
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic results;
    $display("%0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    check(test_mode, 32'h0);
    check(core_inputs, pin_inputs);
    m.xfer(1'b1, 32'h0, 32'h1, rdat, err);
    check(test_functional, 32'h1);
    check(core_out_drive_en, 32'h0);
    $display("enter test done");
    // pin_inputs changes each write: the core must keep the written words instead
    for (int k = 0; k < 3; k++) begin
      d = $random(seed);
      pin_inputs = $random(seed);
      m.xfer(1'b1, 32'h400 >> k, d, rdat, err);
      n = 0;
      repeat (6) begin
        @(posedge sys_clk);
        #2;
        n += (core_step === 1'b1);
      end
      check(n, 32'h1);
      got = k == 0 ? core_coproc_data_in_drive : k == 1 ? core_inputs : core_din;
      check(got, k == 1 ? d & ~`ATSC_INP_ZERO_MASK : d);
    end
    $display("write locations done");
    {core_dout, core_coproc_data_out_sample, core_coproc_instr_sample, address_out_sample} = {4{$random(seed)}} ^
      {$random(seed), $random(seed), $random(seed), $random(seed)};
    {core_status_first_in, core_dbg_hi, instr_register_bits} = $random(seed);
    {core_range_scan, tap_state_bits, core_dbg_lo} = $random(seed);
    for (int b = 2; b < 12; b++) begin
      m.xfer(1'b0, b > 10 ? 32'h0 : 32'h1 << b, 32'h0, rdat, err);
      check(rdat, exp_rd(b));
    end
    m.xfer(1'b0, 32'h082, 32'h0, rdat, err);
    check(err, 32'h1);
    $display("read locations done");
    for (int c = 0; c < 8; c++) begin
      m.xfer(1'b1, 32'h0, c, rdat, err);
      check(test_mode, c == 7 ? 32'h6 : c);
      check(core_out_drive_en, c != 1);
    end
    m.xfer(1'b0, 32'h080, 32'h0, rdat, err);
    check(rdat, 32'h0);
    m.xfer(1'b1, 32'h0, 32'h0, rdat, err);
    pin_inputs = $random(seed);
    #1;
    check(core_inputs, pin_inputs);
    $display("mode codes done");
    results();
  end
endmodule : test_asb_test_slave_controller
